/* button_countdown_timer_ctrl.sv */
`timescale 1ns/10ps
`include "timer_defs.svh"

module button_countdown_timer_ctrl #(
	parameter int unsigned TICK_CYCLES     = `TMR_TICK_CYCLES,
	parameter int unsigned BUZ_HALF_CYCLES = `TMR_BUZ_HALF_CYCLES,
	parameter int unsigned DEB_CYCLES      = `TMR_DEB_CYCLES
) (
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       clk_en_i,
	// User button and straps (pins)
	input  wire logic       button_i,
	input  wire logic       config_strap_a_i,
	input  wire logic       config_strap_b_i,
	input  wire logic       restore_variant_strap_i,
	input  wire logic       turbo_increment_strap_i,
	input  wire logic       second_button_present_i,
	// Display
	output logic [6:0]      display_value_o,
	output logic            display_seconds_o,
	output logic            display_half_o,
	output logic            display_on_o,
	// Buzzer and power
	output logic            buzzer_o,
	output logic            osc_enable_o,
	// Status
	output logic [2:0]      mode_o,
	output logic [1:0]      config_o,
	output logic            single_button_variant_o,
	output logic            dual_button_variant_o
);

	timer_pkg::timer_state_t state_q;
	timer_pkg::timer_state_t state_d;
	timer_pkg::timer_cfg_t   cfg;

	logic [4:0]  strap1_q;
	logic [4:0]  strap2_q;
	logic [23:0] tick_cnt_q;
	logic        tick;
	logic [2:0]  phase_q;
	logic        sec_tick;
	logic        btn_level;
	logic        btn_press;
	logic        btn_release;
	logic        armed_q;
	logic [8:0]  hold_q;
	logic [8:0]  idle_q;
	logic [8:0]  wake_q;
	logic [8:0]  ring_q;
	logic [6:0]  value_q;
	logic [6:0]  min_q;
	logic [6:0]  sec_q;
	logic        inc_one;
	logic        inc_fast;
	logic        turbo_on;
	logic        count_zero;
	logic        enter_prog;
	logic        tone_on;
	logic [14:0] buz_cnt_q;
	logic        buz_sq_q;
	logic [6:0]  disp_val;
	logic        disp_sec;
	logic        disp_half;

	//--------------------------------------------------
	// Button conditioning
	//--------------------------------------------------
	button_conditioner #(
		.DEB_CYCLES (DEB_CYCLES)
	) u_button (
		.core_clk_i (core_clk_i),
		.reset_n_i  (reset_n_i),
		.clk_en_i   (clk_en_i),
		.button_i   (button_i),
		.level_o    (btn_level),
		.press_o    (btn_press),
		.release_o  (btn_release)
	);

	//--------------------------------------------------
	// Strap synchronisers
	//--------------------------------------------------
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			strap1_q <= 5'h00;
			strap2_q <= 5'h00;
		end else if (clk_en_i) begin
			strap1_q <= {second_button_present_i, turbo_increment_strap_i,
			             restore_variant_strap_i, config_strap_b_i, config_strap_a_i};
			strap2_q <= strap1_q;
		end
	end

	always_comb begin
		case ({strap2_q[1], strap2_q[0]})
			2'b00:   cfg = timer_pkg::CFG_MIN_A;
			2'b01:   cfg = timer_pkg::CFG_MIN_B;
			2'b10:   cfg = timer_pkg::CFG_MIN_HALF;
			default: cfg = timer_pkg::CFG_SECONDS;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			single_button_variant_o <= 1'b0;
			dual_button_variant_o   <= 1'b0;
			config_o                <= 2'h0;
			mode_o                  <= 3'h0;
		end else if (clk_en_i) begin
			single_button_variant_o <= strap2_q[2];
			dual_button_variant_o   <= ~strap2_q[2] & strap2_q[4];
			config_o                <= cfg;
			mode_o                  <= state_q;
		end
	end

	//--------------------------------------------------
	// Time base: eighth-second ticks, stopped in power-down
	//--------------------------------------------------
	assign tick     = (tick_cnt_q == 24'(TICK_CYCLES - 1));
	assign sec_tick = tick && (phase_q == `TMR_PHASE_LAST);

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tick_cnt_q <= 24'h000000;
		end else if (clk_en_i) begin
			if (state_q == timer_pkg::ST_OFF || tick) begin
				tick_cnt_q <= 24'h000000;
			end else begin
				tick_cnt_q <= tick_cnt_q + 24'h000001;
			end
		end
	end

	// Phase restarts on every mode change so blink and seconds align to entry
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			phase_q <= 3'h0;
		end else if (clk_en_i) begin
			if (state_d != state_q) begin
				phase_q <= 3'h0;
			end else if (tick) begin
				phase_q <= phase_q + 3'h1;
			end
		end
	end

	//--------------------------------------------------
	// Press and idle timers
	//--------------------------------------------------
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hold_q <= 9'h000;
			idle_q <= 9'h000;
		end else if (clk_en_i) begin
			if (!btn_level) begin
				hold_q <= 9'h000;
			end else if (tick && btn_level && hold_q != `TMR_TICK_SAT) begin
				hold_q <= hold_q + 9'h001;
			end
			if (btn_level || btn_press || state_d != state_q) begin
				idle_q <= 9'h000;
			end else if (tick && idle_q != `TMR_TICK_SAT) begin
				idle_q <= idle_q + 9'h001;
			end
		end
	end

	//--------------------------------------------------
	// Increment decisions in programming
	//--------------------------------------------------
	assign turbo_on = strap2_q[3] && (hold_q >= `TMR_TURBO_TICKS);
	assign inc_fast = tick && btn_level && armed_q && (hold_q >= `TMR_LONG_TICKS)
	                  && (turbo_on || !hold_q[0]);
	assign inc_one  = btn_release && armed_q && (hold_q < `TMR_LONG_TICKS);
	assign count_zero = (min_q == 7'h00) && (sec_q == 7'h00);

	//--------------------------------------------------
	// Mode sequencing
	//--------------------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			timer_pkg::ST_OFF: begin
				if (btn_press) begin
					state_d = timer_pkg::ST_WAKE;
				end
			end
			timer_pkg::ST_WAKE: begin
				if (wake_q >= `TMR_WAKE_TICKS) begin
					state_d = timer_pkg::ST_PROG;
				end
			end
			timer_pkg::ST_PROG: begin
				// A long hold only increments here, never resets
				if (idle_q > `TMR_START_TICKS && value_q != 7'h00) begin
					state_d = timer_pkg::ST_COUNT;
				end else if (idle_q > `TMR_SLEEP_TICKS && value_q == 7'h00) begin
					state_d = timer_pkg::ST_OFF;
				end
			end
			timer_pkg::ST_COUNT: begin
				if (btn_level && hold_q > `TMR_LONG_TICKS) begin
					state_d = timer_pkg::ST_PROG;
				end else if (count_zero) begin
					state_d = timer_pkg::ST_RING;
				end
			end
			timer_pkg::ST_RING: begin
				if (btn_press || ring_q >= `TMR_RING_TICKS) begin
					state_d = timer_pkg::ST_PROG;
				end
			end
			default: state_d = timer_pkg::ST_OFF;
		endcase
	end

	assign enter_prog = (state_d == timer_pkg::ST_PROG) && (state_q != timer_pkg::ST_PROG);

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= timer_pkg::ST_OFF;
		end else if (clk_en_i) begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wake_q <= 9'h000;
		end else if (clk_en_i) begin
			if (state_q != timer_pkg::ST_WAKE) begin
				wake_q <= 9'h000;
			end else if (tick) begin
				wake_q <= wake_q + 9'h001;
			end
		end
	end

	// The press that woke or stopped the timer must be released before it counts
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			armed_q <= 1'b0;
		end else if (clk_en_i) begin
			if (enter_prog) begin
				armed_q <= 1'b0;
			end else if (state_q == timer_pkg::ST_PROG && !btn_level) begin
				armed_q <= 1'b1;
			end
		end
	end

	//--------------------------------------------------
	// Programmed value
	//--------------------------------------------------
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			value_q <= 7'h00;
		end else if (clk_en_i) begin
			if (enter_prog) begin
				value_q <= 7'h00;
			end else if (state_q == timer_pkg::ST_PROG && (inc_one || inc_fast)) begin
				if (value_q == `TMR_VALUE_MAX) begin
					value_q <= 7'h00;
				end else begin
					value_q <= value_q + 7'h01;
				end
			end
		end
	end

	//--------------------------------------------------
	// Countdown: remaining minutes and seconds
	//--------------------------------------------------
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			min_q <= 7'h00;
			sec_q <= 7'h00;
		end else if (clk_en_i) begin
			if (state_q == timer_pkg::ST_PROG) begin
				if (cfg == timer_pkg::CFG_SECONDS) begin
					min_q <= 7'h00;
					sec_q <= value_q;
				end else begin
					min_q <= value_q;
					sec_q <= 7'h00;
				end
			end else if (state_q == timer_pkg::ST_COUNT && sec_tick && !count_zero) begin
				if (sec_q != 7'h00) begin
					sec_q <= sec_q - 7'h01;
				end else begin
					min_q <= min_q - 7'h01;
					sec_q <= `TMR_SEC_MAX;
				end
			end
		end
	end

	//--------------------------------------------------
	// Ringing sequence and buzzer
	//--------------------------------------------------
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ring_q <= 9'h000;
		end else if (clk_en_i) begin
			if (state_q != timer_pkg::ST_RING) begin
				ring_q <= 9'h000;
			end else if (tick) begin
				ring_q <= ring_q + 9'h001;
			end
		end
	end

	// Each burst second holds three eighth-second tones at phases 0, 2 and 4
	assign tone_on = (state_q == timer_pkg::ST_RING)
	                 && (ring_q < `TMR_BURST_TICKS || ring_q >= `TMR_BURST2_TICKS)
	                 && !ring_q[0] && (ring_q[2:0] <= 3'h4);

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			buz_cnt_q <= 15'h0000;
			buz_sq_q  <= 1'b0;
			buzzer_o  <= 1'b0;
		end else if (clk_en_i) begin
			if (!tone_on) begin
				buz_cnt_q <= 15'h0000;
				buz_sq_q  <= 1'b0;
			end else if (buz_cnt_q == 15'(BUZ_HALF_CYCLES - 1)) begin
				buz_cnt_q <= 15'h0000;
				buz_sq_q  <= ~buz_sq_q;
			end else begin
				buz_cnt_q <= buz_cnt_q + 15'h0001;
			end
			buzzer_o <= tone_on & buz_sq_q;
		end
	end

	//--------------------------------------------------
	// Display content
	//--------------------------------------------------
	always_comb begin
		disp_val  = value_q;
		disp_sec  = (cfg == timer_pkg::CFG_SECONDS);
		disp_half = 1'b0;
		if (state_q == timer_pkg::ST_COUNT) begin
			if (cfg == timer_pkg::CFG_SECONDS) begin
				disp_val = sec_q;
			end else if (min_q == 7'h00 && cfg != timer_pkg::CFG_MIN_B) begin
				disp_val = sec_q;
				disp_sec = 1'b1;
			end else if (cfg == timer_pkg::CFG_MIN_HALF && min_q < `TMR_HALF_UPPER_MIN
			             && sec_q != 7'h00 && sec_q <= `TMR_HALF_SEC) begin
				disp_val  = min_q;
				disp_half = 1'b1;
			end else if (sec_q != 7'h00) begin
				disp_val = min_q + 7'h01;
			end else begin
				disp_val = min_q;
			end
		end else if (state_q != timer_pkg::ST_PROG) begin
			disp_val = 7'h00;
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			display_value_o   <= 7'h00;
			display_seconds_o <= 1'b0;
			display_half_o    <= 1'b0;
			display_on_o      <= 1'b0;
			osc_enable_o      <= 1'b0;
		end else if (clk_en_i) begin
			display_value_o   <= disp_val;
			display_seconds_o <= disp_sec;
			display_half_o    <= disp_half;
			osc_enable_o      <= (state_q != timer_pkg::ST_OFF);
			case (state_q)
				timer_pkg::ST_OFF:   display_on_o <= 1'b0;
				timer_pkg::ST_COUNT,
				timer_pkg::ST_RING:  display_on_o <= (phase_q < `TMR_BLINK_ON_LIM);
				default:             display_on_o <= 1'b1;
			endcase
		end
	end

endmodule : button_countdown_timer_ctrl

/* timer_defs.svh */
// Function
// - Buzzer carries a 2048 Hz square wave while a tone sounds.
// - Two config straps select configurations 1 to 4; both high is seconds mode.
// - Config 1 shows last minute in seconds; config 2 keeps minutes.
// - Config 3 steps half minutes from 10 to 1 minute, then seconds.
// - Restore strap high picks one-button variant, low with second button two-button.
// - Second fast speed only when the turbo strap is high.
// - Press wakes from power-down within two seconds, shows steady 00, programs.
// - Programming display steady; each short press adds one.
// - Hold over one second adds four per second.
// - With turbo strap, hold over five seconds adds eight per second.
// - Release returns to single increment; modes may alternate freely.
// - Passing 99 wraps to 00.
// - Long hold during programming never resets.
// - Released over two seconds with nonzero value starts countdown.
// - Showing 00 without press for over 45 seconds powers down.
// - Countdown blinks: half second on, half second off.
// - Countdown reaching zero enters ringing.
// - Countdown hold over one second aborts to programming at 00.
// - Ring ten 3-tone groups, 20 s silence, ten more groups.
// - After full ringing, value 00 and programming mode.
// - Ringing blinks; any press stops it, programming at 00.
// - Power-down stops oscillator and display until a wake press.
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

//--------------------------------------------------
// Clock and derived cycle counts
//--------------------------------------------------
`define TMR_CLK_HZ          100000000
`define TMR_TICK_HZ         8
`define TMR_TICK_CYCLES     (`TMR_CLK_HZ / `TMR_TICK_HZ)
`define TMR_BUZ_HZ          2048
`define TMR_BUZ_HALF_CYCLES (`TMR_CLK_HZ / (2 * `TMR_BUZ_HZ))
`define TMR_DEB_MS          10
`define TMR_DEB_CYCLES      (`TMR_CLK_HZ / 1000 * `TMR_DEB_MS)

//--------------------------------------------------
// Times in seconds (wake-up in milliseconds) and their counts in eighth-second ticks
//--------------------------------------------------
`define TMR_LONG_S          1
`define TMR_START_S         2
`define TMR_TURBO_S         5
`define TMR_SLEEP_S         45
`define TMR_BURST_S         10
`define TMR_BURST2_S        30
`define TMR_RING_S          40
`define TMR_WAKE_MS         500
`define TMR_LONG_TICKS      9'(`TMR_LONG_S * `TMR_TICK_HZ)
`define TMR_START_TICKS     9'(`TMR_START_S * `TMR_TICK_HZ)
`define TMR_TURBO_TICKS     9'(`TMR_TURBO_S * `TMR_TICK_HZ)
`define TMR_SLEEP_TICKS     9'(`TMR_SLEEP_S * `TMR_TICK_HZ)
`define TMR_BURST_TICKS     9'(`TMR_BURST_S * `TMR_TICK_HZ)
`define TMR_BURST2_TICKS    9'(`TMR_BURST2_S * `TMR_TICK_HZ)
`define TMR_RING_TICKS      9'(`TMR_RING_S * `TMR_TICK_HZ)
`define TMR_WAKE_TICKS      9'(`TMR_WAKE_MS * `TMR_TICK_HZ / 1000)
`define TMR_TICK_SAT        9'h1FF

//--------------------------------------------------
// Values
//--------------------------------------------------
`define TMR_VALUE_MAX       7'h63
`define TMR_SEC_MAX         7'h3B
`define TMR_HALF_SEC        7'h1E
`define TMR_HALF_UPPER_MIN  7'h0A
`define TMR_PHASE_LAST      3'h7
`define TMR_BLINK_ON_LIM    3'h4

`endif

/* timer_pkg.sv */
package timer_pkg;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_WAKE,
		ST_PROG,
		ST_COUNT,
		ST_RING
	} timer_state_t;

	typedef enum logic [1:0] {
		CFG_MIN_A,
		CFG_MIN_B,
		CFG_MIN_HALF,
		CFG_SECONDS
	} timer_cfg_t;

endpackage : timer_pkg

/* button_conditioner.sv */
`timescale 1ns/10ps
`include "timer_defs.svh"

module button_conditioner #(
	parameter int unsigned DEB_CYCLES = `TMR_DEB_CYCLES
) (
	// Clock and reset
	input  wire logic core_clk_i,
	input  wire logic reset_n_i,
	input  wire logic clk_en_i,
	// Raw pin
	input  wire logic button_i,
	// Conditioned button
	output logic      level_o,
	output logic      press_o,
	output logic      release_o
);

	logic        sync1_q;
	logic        sync2_q;
	logic [23:0] deb_q;

	//--------------------------------------------------
	// Synchroniser
	//--------------------------------------------------
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else if (clk_en_i) begin
			sync1_q <= button_i;
			sync2_q <= sync1_q;
		end
	end

	//--------------------------------------------------
	// Debounce: level must hold steady for DEB_CYCLES
	//--------------------------------------------------
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			deb_q     <= 24'h000000;
			level_o   <= 1'b0;
			press_o   <= 1'b0;
			release_o <= 1'b0;
		end else if (clk_en_i) begin
			press_o   <= 1'b0;
			release_o <= 1'b0;
			if (sync2_q == level_o) begin
				deb_q <= 24'h000000;
			end else if (deb_q >= 24'(DEB_CYCLES - 1)) begin
				deb_q     <= 24'h000000;
				level_o   <= sync2_q;
				press_o   <= sync2_q;
				release_o <= ~sync2_q;
			end else begin
				deb_q <= deb_q + 24'h000001;
			end
		end
	end

endmodule : button_conditioner

/* timer_ctrl_props.sv */
`timescale 1ns/10ps
module timer_ctrl_props #(
	parameter int unsigned TICK_CYCLES     = 16,
	parameter int unsigned BUZ_HALF_CYCLES = 2,
	parameter int unsigned DEB_CYCLES      = 3
) (
	// Clock and reset
	input wire logic       core_clk_i,
	input wire logic       reset_n_i,
	// Watched outputs
	input wire logic [6:0] display_value_o,
	input wire logic       display_on_o,
	input wire logic       buzzer_o,
	input wire logic       osc_enable_o,
	input wire logic [2:0] mode_o
);
	localparam int WAKE_MAX  = 16 * TICK_CYCLES;
	localparam int BLINK_MAX = 4 * TICK_CYCLES + 2;
	logic [15:0] hi_q;
	logic [15:0] same_q;
	logic        on_q;
	logic [2:0]  mode_q;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	// ------------------------------------------
	// Run lengths of buzzer high and of a steady display
	// ------------------------------------------
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hi_q   <= '0;
			same_q <= '0;
			on_q   <= 1'b0;
			mode_q <= 3'h0;
		end else begin
			hi_q   <= buzzer_o ? hi_q + 16'h0001 : 16'h0000;
			on_q   <= display_on_o;
			mode_q <= mode_o;
			// A mode change restarts the blink phase, so the run restarts too
			same_q <= (mode_o >= 3'h3 && mode_o == mode_q && display_on_o == on_q) ?
				same_q + 16'h0001 : 16'h0000;
		end
	end
	sequence s_woke;
		mode_o == 3'h1 ##1 mode_o == 3'h2;
	endsequence
	sequence s_slept;
		mode_o == 3'h2 ##1 mode_o == 3'h0;
	endsequence
	a_buzz_half: assert property (hi_q <= 16'(BUZ_HALF_CYCLES))
		else $error("buzzer high beyond half period");
	a_buzz_quiet: assert property ((mode_o != 3'h4) [*3] |-> !buzzer_o)
		else $error("buzzer sounds outside ringing");
	a_osc_dark: assert property ((mode_o == 3'h0) [*2] |-> !osc_enable_o && !display_on_o)
		else $error("oscillator or display on in power-down");
	a_wake_time: assert property ($rose(mode_o == 3'h1) |-> ##[1:WAKE_MAX] mode_o == 3'h2)
		else $error("wake-up too slow");
	a_wake_zero: assert property (s_woke |=> display_value_o == 7'h00 && display_on_o)
		else $error("wake-up not at steady 00");
	a_prog_steady: assert property ((mode_o == 3'h2) [*2] |-> display_on_o)
		else $error("display blinks in programming");
	a_count_entry: assert property ($rose(mode_o == 3'h3) |->
		$past(mode_o) == 3'h2 && $past(display_value_o) != 7'h00) else $error("bad countdown start");
	a_ring_entry: assert property ($rose(mode_o == 3'h4) |-> $past(mode_o) == 3'h3)
		else $error("ringing not from countdown");
	a_ring_exit: assert property ($fell(mode_o == 3'h4) |-> mode_o == 3'h2 ##1 display_value_o == 7'h00)
		else $error("ringing exit not programming at 00");
	a_sleep_zero: assert property (s_slept |-> $past(display_value_o) == 7'h00)
		else $error("power-down with nonzero value");
	a_blink_half: assert property (same_q <= 16'(BLINK_MAX))
		else $error("display steady too long while blinking");
endmodule : timer_ctrl_props
bind button_countdown_timer_ctrl timer_ctrl_props #(
	.TICK_CYCLES    (TICK_CYCLES),
	.BUZ_HALF_CYCLES(BUZ_HALF_CYCLES),
	.DEB_CYCLES     (DEB_CYCLES)
) u_props (
	.core_clk_i     (core_clk_i),
	.reset_n_i      (reset_n_i),
	.display_value_o(display_value_o),
	.display_on_o   (display_on_o),
	.buzzer_o       (buzzer_o),
	.osc_enable_o   (osc_enable_o),
	.mode_o         (mode_o)
);

/* timer_user_model.sv */
`timescale 1ns/10ps
module timer_user_model (
	// Clock
	input  wire logic core_clk_i,
	// Buzzer heard by the user
	input  wire logic buzzer_i,
	// Button contact, pulled low when open
	output logic      button_o
);
	int   rises = 0;
	logic last_q = 1'b0;
	initial button_o = 1'b0;
	// Rising edges heard, so the tone rate can be measured
	always @(posedge core_clk_i) begin
		if (buzzer_i && !last_q)
			rises++;
		last_q <= buzzer_i;
	end
	// One bounce shorter than the debounce window, then a clean hold
	task automatic push(input int hold);
		@(negedge core_clk_i) button_o = 1'b1;
		@(negedge core_clk_i) button_o = 1'b0;
		@(negedge core_clk_i) button_o = 1'b1;
		repeat (hold) @(negedge core_clk_i);
		button_o = 1'b0;
	endtask : push
endmodule : timer_user_model

/* button_countdown_timer_ctrl_bench.sv */
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module button_countdown_timer_ctrl_bench;
	localparam int T = 16;
	localparam int S = 8 * T;
	int         miscompares;
	int         checked;
	int         n;
	logic [6:0] v;
	logic       core_clk_i, reset_n_i, clk_en_i, button_i, config_strap_a_i, config_strap_b_i;
	logic       restore_variant_strap_i, turbo_increment_strap_i, second_button_present_i;
	logic [6:0] display_value_o;
	logic       display_seconds_o, display_half_o, display_on_o, buzzer_o, osc_enable_o;
	logic [2:0] mode_o;
	logic [1:0] config_o;
	logic       single_button_variant_o, dual_button_variant_o;
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	timer_user_model U (.core_clk_i, .buzzer_i(buzzer_o), .button_o(button_i));
	// Short counts keep the run brief; every wait below is in clock cycles, with S cycles to one second
	button_countdown_timer_ctrl #(.TICK_CYCLES(T), .BUZ_HALF_CYCLES(2), .DEB_CYCLES(3)) DUT (
		.core_clk_i, .reset_n_i, .clk_en_i, .button_i, .config_strap_a_i,
		.config_strap_b_i, .restore_variant_strap_i, .turbo_increment_strap_i,
		.second_button_present_i, .display_value_o, .display_seconds_o, .display_half_o,
		.display_on_o, .buzzer_o, .osc_enable_o, .mode_o, .config_o,
		.single_button_variant_o, .dual_button_variant_o);
	function automatic logic [6:0] wrap_add(input logic [6:0] a, input int k);
		return 7'((int'(a) + k) % 100);
	endfunction : wrap_add
	function automatic logic [1:0] cfg_code(input logic a, input logic b);
		return {b, a};
	endfunction : cfg_code
	task automatic cyc(input int k);
		repeat (k) @(negedge core_clk_i);
	endtask : cyc
	task automatic wait_mode(input logic [2:0] m, input int lim);
		for (int i = 0; i < lim && mode_o !== m; i++)
			cyc(1);
		`CHK(mode_o, m)
	endtask : wait_mode
	task automatic listen(input int skip, input int span, input int exp);
		int r;
		cyc(skip);
		r = U.rises;
		cyc(span);
		`CHK(U.rises - r, exp)
	endtask : listen
	task automatic wrap_up;
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	// Watchdog: the full sequence needs about 25000 cycles
	initial begin
		cyc(40000);
		miscompares++;
		wrap_up();
	end
	// ------------------------------------------
	// Main sequence
	// ------------------------------------------
	initial begin
		reset_n_i = 1'b0;
		clk_en_i = 1'b1;
		turbo_increment_strap_i = 1'b1;
		{config_strap_a_i, config_strap_b_i, restore_variant_strap_i, second_button_present_i} = 4'h0;
		void'($urandom(32'h8B48E8AC));
		cyc(16);
		reset_n_i = 1'b1;
		`CHK(osc_enable_o, 1'b0)
		for (n = 0; n < 12; n++) begin
			{config_strap_b_i, config_strap_a_i} = (n < 4) ? 2'(n) : 2'($urandom);
			{restore_variant_strap_i, second_button_present_i} = 2'($urandom);
			turbo_increment_strap_i = 1'($urandom);
			cyc(6);
			`CHK(config_o, cfg_code(config_strap_a_i, config_strap_b_i))
			`CHK(single_button_variant_o, restore_variant_strap_i)
			`CHK(dual_button_variant_o, !restore_variant_strap_i && second_button_present_i)
		end
		$display("test straps done");
		{config_strap_b_i, config_strap_a_i} = 2'b11;
		turbo_increment_strap_i = 1'b1;
		U.push(20);
		wait_mode(3'h2, 2 * S);
		cyc(2);
		`CHK(display_value_o, 7'h00)
		$display("test wake done");
		n = 1 + $urandom % 3;
		repeat (n) begin
			U.push(10 + $urandom % 40);
			cyc(20);
		end
		`CHK(display_value_o, wrap_add(7'h00, n))
		$display("test single done");
		// A frozen block must miss a whole press
		clk_en_i = 1'b0;
		v = display_value_o;
		U.push(10 + $urandom % 40);
		cyc(20);
		`CHK(display_value_o, v)
		clk_en_i = 1'b1;
		$display("test freeze done");
		// Long hold runs past 99 so the wrap is crossed at the fast rate
		fork
			U.push(19 * S);
		join_none
		cyc(2 * S);
		v = display_value_o;
		cyc(S);
		`CHK(display_value_o, wrap_add(v, 4))
		cyc(3 * S);
		for (n = 0; n < 12; n++) begin
			v = display_value_o;
			cyc(S);
			`CHK(display_value_o, wrap_add(v, 8))
		end
		wait fork;
		cyc(20);
		`CHK(mode_o, 3'h2)
		turbo_increment_strap_i = 1'b0;
		fork
			U.push(8 * S);
		join_none
		cyc(6 * S);
		v = display_value_o;
		cyc(S);
		`CHK(display_value_o, wrap_add(v, 4))
		wait fork;
		cyc(20);
		$display("test fast done");
		// Short counts would reach ringing before the abort hold is seen
		while (display_value_o < 7'h03) begin
			U.push(20);
			cyc(20);
		end
		cyc(S);
		`CHK(mode_o, 3'h2)
		wait_mode(3'h3, 2 * S);
		`CHK(display_seconds_o, 1'b1)
		U.push(2 * S);
		wait_mode(3'h2, S);
		cyc(2);
		`CHK(display_value_o, 7'h00)
		$display("test abort done");
		repeat (2) begin
			cyc(20);
			U.push(20);
		end
		wait_mode(3'h3, 3 * S);
		wait_mode(3'h4, 3 * S);
		listen(S - 8, S, 12);
		listen(9 * S, 18 * S, 0);
		listen(S, S, 12);
		wait_mode(3'h2, 11 * S);
		cyc(2);
		`CHK(display_value_o, 7'h00)
		$display("test ring done");
		U.push(20);
		cyc(20);
		wait_mode(3'h3, 3 * S);
		wait_mode(3'h4, 2 * S);
		cyc(S);
		U.push(20);
		wait_mode(3'h2, S);
		cyc(2);
		`CHK(display_value_o, 7'h00)
		$display("test ring stop done");
		cyc(44 * S);
		`CHK(mode_o, 3'h2)
		wait_mode(3'h0, 2 * S);
		cyc(2);
		`CHK(osc_enable_o, 1'b0)
		U.push(20);
		wait_mode(3'h2, 2 * S);
		$display("test sleep done");
		for (n = 0; n < 3; n++) begin
			{config_strap_b_i, config_strap_a_i} = 2'(n);
			cyc(20);
			U.push(20);
			wait_mode(3'h3, 3 * S);
			cyc(S + 8);
			`CHK(display_value_o, (n == 1) ? 7'h01 : 7'h3B)
			`CHK(display_seconds_o, n != 1)
			U.push(2 * S);
			wait_mode(3'h2, S);
		end
		$display("test minutes done");
		repeat (2) begin
			cyc(20);
			U.push(20);
		end
		wait_mode(3'h3, 3 * S);
		cyc(31 * S);
		`CHK(display_value_o, 7'h01)
		`CHK(display_half_o, 1'b1)
		$display("test half done");
		reset_n_i = 1'b0;
		cyc(2);
		reset_n_i = 1'b1;
		`CHK(mode_o, 3'h0)
		`CHK(display_on_o, 1'b0)
		`CHK(osc_enable_o, 1'b0)
		$display("test reset done");
		wrap_up();
	end
endmodule : button_countdown_timer_ctrl_bench
